// >>> hw/pcp_top.v
// Serial port, frame capture and pin control of the motion sensor
`timescale 1ns/1ps
`default_nettype none
`include "pcp_defines.vh"

module pcp_top #(
   parameter PIX_W      = 6,
   parameter IDX_W      = 11,
   parameter DEPTH      = 1536,
   parameter [7:0] PART_ID    = 8'h5a,  // Arbitrary value
   parameter [7:0] FW_REV_ID  = 8'h3c   // Arbitrary value
) (
   // Clock and reset
   input  wire             CLK_I,
   input  wire             RESET_N_I,
   // Serial port pins
   input  wire             SCLK_I,
   input  wire             MOSI_I,
   input  wire             CHIP_SELECT_N_I,
   output reg              MISO_O,
   output reg              MISO_OE_O,
   output reg              PULLUP_EN_O,
   // Power control
   input  wire             SLEEP_N_I,
   output reg              OSC_EN_O,
   // Pixel array side
   input  wire [PIX_W-1:0] PIX_DATA_I,
   input  wire             PIX_VALID_I,
   input  wire             PIX_FRAME_START_I,
   input  wire             LIGHT_WINDOW_I,
   // Lighting and core status
   output reg              LED_CTRL_O,
   output reg              TRACKING_EN_O,
   output reg              FIRMWARE_VALID_O
);

   // ----------------------------------------------------------------
   // Capture states
   // ----------------------------------------------------------------
   localparam [1:0] CAP_IDLE = 2'd0;
   localparam [1:0] CAP_ARM  = 2'd1;
   localparam [1:0] CAP_FILL = 2'd2;
   localparam [1:0] CAP_DONE = 2'd3;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Bit order: 3 sleep_n, 2 chip_select_n, 1 mosi, 0 sclk
   reg  [3:0] sync1_q;
   reg  [3:0] sync2_q;
   reg        sclk_d1_q;

   always @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         sync1_q   <= 4'hf;
         sync2_q   <= 4'hf;
         sclk_d1_q <= 1'b1;
      end
      else
      begin
         sync1_q   <= {SLEEP_N_I, CHIP_SELECT_N_I, MOSI_I, SCLK_I};
         sync2_q   <= sync1_q;
         sclk_d1_q <= sync2_q[0];
      end
   end

   wire sleep_n_s       = sync2_q[3];
   wire chip_select_n_s = sync2_q[2];
   wire mosi_s          = sync2_q[1];
   wire sclk_s          = sync2_q[0];
   wire asleep          = ~sleep_n_s;

   // Port held in reset while deselected or asleep
   wire port_off  = chip_select_n_s | asleep;
   wire sclk_rise = ~port_off & sclk_s & ~sclk_d1_q;
   wire sclk_fall = ~port_off & ~sclk_s & sclk_d1_q;

   // ----------------------------------------------------------------
   // Register and serial state
   // ----------------------------------------------------------------
   reg  [7:0]       config_q;
   reg  [1:0]       cap_state_q;
   reg  [IDX_W-1:0] wr_idx_q;
   reg  [IDX_W-1:0] rd_idx_q;
   reg              phase_q;     // 0 address byte, 1 data byte
   reg  [2:0]       bit_cnt_q;
   reg  [6:0]       shift_q;
   reg              dir_wr_q;
   reg  [6:0]       addr_q;
   reg              burst_q;
   reg              load_pend_q;
   reg  [7:0]       tx_q;

   wire [PIX_W-1:0] mem_data;
   wire [7:0]       rx_byte  = {shift_q, mosi_s};
   wire             byte_end = sclk_rise & (bit_cnt_q == `PCP_BITS_PER_BYTE);
   wire             addr_end = byte_end & ~phase_q;
   wire             data_end = byte_end & phase_q;
   wire             wr_fire  = data_end & dir_wr_q;
   wire             cap_trig = wr_fire & (addr_q == `PCP_ADDR_FRAME_CAPTURE);
   wire             cap_done = (cap_state_q == CAP_DONE);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Streamed byte for a stream index
   function [7:0] pix_byte;
      input             done;
      input [IDX_W-1:0] idx;
      input [PIX_W-1:0] data;
      reg               mark;
      begin
         mark = (idx == {IDX_W{1'b0}}) | (idx == `PCP_FRAME_BYTES);
         if (done && (idx < `PCP_TOTAL_BYTES))
         begin
            pix_byte = {1'b1, mark, data};
         end
         else
         begin
            pix_byte = 8'h00;
         end
      end
   endfunction

   // Read decode; unmapped addresses answer zero
   function [7:0] reg_read;
      input [6:0] addr;
      input [7:0] cfg;
      input       fw_ok;
      input [7:0] pixel;
      begin
         case (addr)
            `PCP_ADDR_PART_ID:       reg_read = PART_ID;
            `PCP_ADDR_PART_ID_COMPL: reg_read = ~PART_ID;
            `PCP_ADDR_CONFIG:        reg_read = cfg;
            `PCP_ADDR_FW_REVISION:   reg_read = fw_ok ? FW_REV_ID : 8'h00;
            `PCP_ADDR_FRAME_CAPTURE: reg_read = pixel;
            `PCP_ADDR_PIXEL_BURST:   reg_read = pixel;
            default:                 reg_read = 8'h00;
         endcase
      end
   endfunction

   wire [7:0] cur_pixel = pix_byte(cap_done, rd_idx_q, mem_data);
   wire [7:0] rd_word   = reg_read(addr_q, config_q, FIRMWARE_VALID_O, cur_pixel);

   // ----------------------------------------------------------------
   // Serial port
   // ----------------------------------------------------------------
   always @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         phase_q     <= 1'b0;
         bit_cnt_q   <= 3'h0;
         shift_q     <= 7'h00;
         dir_wr_q    <= 1'b0;
         addr_q      <= 7'h00;
         burst_q     <= 1'b0;
         load_pend_q <= 1'b0;
         tx_q        <= 8'h00;
         MISO_O      <= 1'b0;
      end
      else if (port_off)
      begin
         // Abort: no write happens, registers are untouched
         phase_q     <= 1'b0;
         bit_cnt_q   <= 3'h0;
         burst_q     <= 1'b0;
         load_pend_q <= 1'b0;
         MISO_O      <= 1'b0;
      end
      else
      begin
         if (sclk_rise)
         begin
            shift_q   <= rx_byte[6:0];
            bit_cnt_q <= bit_cnt_q + 3'h1;
         end
         if (addr_end)
         begin
            dir_wr_q    <= rx_byte[`PCP_DIR_BIT];
            addr_q      <= rx_byte[6:0];
            phase_q     <= 1'b1;
            load_pend_q <= ~rx_byte[`PCP_DIR_BIT];
            burst_q     <= ~rx_byte[`PCP_DIR_BIT] &
                           (rx_byte[6:0] == `PCP_ADDR_PIXEL_BURST);
         end
         else if (data_end)
         begin
            // A burst keeps streaming until chip select rises
            phase_q     <= burst_q;
            load_pend_q <= burst_q;
         end
         if (sclk_fall && phase_q && !dir_wr_q)
         begin
            if (load_pend_q)
            begin
               load_pend_q <= 1'b0;
               MISO_O      <= rd_word[7];
               tx_q        <= {rd_word[6:0], 1'b0};
            end
            else
            begin
               MISO_O <= tx_q[7];
               tx_q   <= {tx_q[6:0], 1'b0};
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Stream index
   // ----------------------------------------------------------------
   wire pix_read_end = data_end & ~dir_wr_q & cap_done & (rd_idx_q < `PCP_TOTAL_BYTES) &
                       (burst_q | (addr_q == `PCP_ADDR_FRAME_CAPTURE));

   always @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         rd_idx_q <= {IDX_W{1'b0}};
      end
      else if (cap_trig)
      begin
         rd_idx_q <= {IDX_W{1'b0}};
      end
      else if (addr_end && !rx_byte[`PCP_DIR_BIT] &&
               (rx_byte[6:0] == `PCP_ADDR_PIXEL_BURST))
      begin
         // Every burst restarts at the first stored byte
         rd_idx_q <= {IDX_W{1'b0}};
      end
      else if (pix_read_end)
      begin
         // Saturates past the end so later reads give zero
         rd_idx_q <= rd_idx_q + {{(IDX_W-1){1'b0}}, 1'b1};
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   always @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         config_q         <= `PCP_CONFIG_RESET;
         TRACKING_EN_O    <= 1'b1;
         FIRMWARE_VALID_O <= 1'b1;
      end
      else
      begin
         if (wr_fire && (addr_q == `PCP_ADDR_CONFIG))
         begin
            config_q <= rx_byte;
         end
         if (cap_trig)
         begin
            // Only a hardware reset brings tracking back
            TRACKING_EN_O    <= 1'b0;
            FIRMWARE_VALID_O <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Capture engine
   // ----------------------------------------------------------------
   // Fill starts on a frame start so byte 0 is a frame's first pixel
   wire mem_we = PIX_VALID_I & ~asleep &
                 (((cap_state_q == CAP_ARM) & PIX_FRAME_START_I) |
                  (cap_state_q == CAP_FILL));

   always @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         cap_state_q <= CAP_IDLE;
         wr_idx_q    <= {IDX_W{1'b0}};
      end
      else if (cap_trig)
      begin
         cap_state_q <= CAP_ARM;
         wr_idx_q    <= {IDX_W{1'b0}};
      end
      else
      begin
         case (cap_state_q)
            CAP_IDLE:
            begin
               cap_state_q <= CAP_IDLE;
            end
            CAP_ARM:
            begin
               if (mem_we)
               begin
                  cap_state_q <= CAP_FILL;
                  wr_idx_q    <= wr_idx_q + {{(IDX_W-1){1'b0}}, 1'b1};
               end
            end
            CAP_FILL:
            begin
               if (mem_we)
               begin
                  if (wr_idx_q == `PCP_LAST_BYTE)
                  begin
                     cap_state_q <= CAP_DONE;
                  end
                  wr_idx_q <= wr_idx_q + {{(IDX_W-1){1'b0}}, 1'b1};
               end
            end
            CAP_DONE:
            begin
               cap_state_q <= CAP_DONE;
            end
            default:
            begin
               cap_state_q <= CAP_IDLE;
            end
         endcase
      end
   end

   pcp_pixel_mem #(
      .DEPTH     (DEPTH),
      .AW        (IDX_W),
      .DW        (PIX_W)
   ) u_mem (
      .clk_i     (CLK_I),
      .wr_en_i   (mem_we),
      .wr_addr_i (wr_idx_q),
      .wr_data_i (PIX_DATA_I),
      .rd_addr_i (rd_idx_q),
      .rd_data_o (mem_data)
   );

   // ----------------------------------------------------------------
   // Pins: drive enable, pull-ups, oscillator, lighting
   // ----------------------------------------------------------------
   // All but OSC_EN_O sit at their off state while reset is held; OSC_EN_O resets to on
   always @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         MISO_OE_O   <= 1'b0;
         PULLUP_EN_O <= 1'b0;
         OSC_EN_O    <= 1'b1;
         LED_CTRL_O  <= 1'b0;
      end
      else
      begin
         MISO_OE_O   <= ~chip_select_n_s;
         PULLUP_EN_O <= sleep_n_s;
         OSC_EN_O    <= sleep_n_s;
         if (asleep)
         begin
            LED_CTRL_O <= 1'b0;
         end
         else if (config_q[`PCP_LED_MODE_BIT])
         begin
            LED_CTRL_O <= LIGHT_WINDOW_I;
         end
         else
         begin
            LED_CTRL_O <= 1'b1;
         end
      end
   end

endmodule // pcp_top

`default_nettype wire

// >>> inc/pcp_defines.vh
// Constants for the pixel capture serial port block
//
// Operation
// - Capture trigger stores next 1536 pixel bytes
// - Capture stops tracking, kills downloaded firmware
// - Pixel burst streams consecutive bytes per read
// - Burst before capture done returns zeros
// - First 900 bytes frame, 636 follow
// - Bit 6 marks bytes 1 and 901
// - Every pixel byte has MSB set
// - Bytes from 1537 onward read zero
// - Chip select high ends burst, aborts read
// - Capture register reads one pixel each
// - Chip select pulse resets port, keeps registers
// - Unassigned address: write ignored, read zero
// - Aborted transfer writes nothing, resets port
// - Host must pulse reset after power-up
// - Sleep halts oscillator, keeps registers
// - Sleep: pull-ups off, inputs ignored, light low; chip select still drives MISO_OE_O
// - Reset: pull-ups off, light low, inputs ignored
// - Light drive continuous or exposure-window mode
// - Address byte, direction bit, then data byte
// - Chip select high: inputs ignored, output off
`ifndef PCP_DEFINES_VH
`define PCP_DEFINES_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define PCP_ADDR_PART_ID       7'h00
`define PCP_ADDR_CONFIG        7'h0a
`define PCP_ADDR_FRAME_CAPTURE 7'h13
`define PCP_ADDR_FW_REVISION   7'h1f
`define PCP_ADDR_PART_ID_COMPL 7'h3f
`define PCP_ADDR_PIXEL_BURST   7'h40

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define PCP_CONFIG_RESET       8'h09
`define PCP_LED_MODE_BIT       6
`define PCP_DIR_BIT            7
`define PCP_MARK_BIT           6
`define PCP_VALID_BIT          7

// ----------------------------------------------------------------
// Capture counts
// ----------------------------------------------------------------
`define PCP_TOTAL_BYTES        11'd1536
`define PCP_LAST_BYTE          11'd1535
`define PCP_FRAME_BYTES        11'd900
`define PCP_BITS_PER_BYTE      3'd7

`endif

// >>> hw/pcp_pixel_mem.v
// Capture memory holding the stored pixel values
`timescale 1ns/1ps
`default_nettype none

module pcp_pixel_mem #(
   parameter DEPTH  = 1536,
   parameter AW     = 11,
   parameter DW     = 6
) (
   // Clock
   input  wire          clk_i,
   // Write side
   input  wire          wr_en_i,
   input  wire [AW-1:0] wr_addr_i,
   input  wire [DW-1:0] wr_data_i,
   // Read side, one cycle latency
   input  wire [AW-1:0] rd_addr_i,
   output reg  [DW-1:0] rd_data_o
);

   reg [DW-1:0] mem [0:DEPTH-1];

   // No reset on the array; contents only matter after a full fill
   always @(posedge clk_i)
   begin
      if (wr_en_i)
      begin
         mem[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem[rd_addr_i];
   end

endmodule // pcp_pixel_mem

`default_nettype wire

// >>> test/pcp_top_asserts.sv
// Port-level assertions for the pixel capture serial port
`timescale 1ns/1ps
`default_nettype none
module pcp_top_asserts (
   // Clock, reset and input pins
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   input wire logic SCLK_I,
   input wire logic CHIP_SELECT_N_I,
   input wire logic SLEEP_N_I,
   // Observed outputs
   input wire logic MISO_O,
   input wire logic MISO_OE_O,
   input wire logic PULLUP_EN_O,
   input wire logic OSC_EN_O,
   input wire logic LED_CTRL_O,
   input wire logic TRACKING_EN_O,
   input wire logic FIRMWARE_VALID_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RESET_N_I);
   // ------------------------------------------------------------
   // Serial pins; windows allow for the two-stage synchroniser
   // ------------------------------------------------------------
   AST_OE_OFF: assert property (CHIP_SELECT_N_I [*4] |-> !MISO_OE_O)
      else $error("data out enabled while deselected");
   AST_OE_ON: assert property (!CHIP_SELECT_N_I [*5] |-> MISO_OE_O)
      else $error("data out not enabled while selected");
   AST_MISO_IDLE: assert property (CHIP_SELECT_N_I [*4] |-> !MISO_O)
      else $error("data out not low while deselected");
   AST_MISO_HOLD: assert property
      ((SCLK_I && !CHIP_SELECT_N_I && SLEEP_N_I) [*4] |-> $stable(MISO_O))
      else $error("data out moved while serial clock high");
   // ------------------------------------------------------------
   // Power and core state
   // ------------------------------------------------------------
   AST_SLEEP_PINS: assert property
      (!SLEEP_N_I [*4] |-> !(LED_CTRL_O || PULLUP_EN_O || OSC_EN_O))
      else $error("light, pull-ups or oscillator on in sleep");
   AST_PULLUP_ON: assert property (SLEEP_N_I [*4] |-> PULLUP_EN_O)
      else $error("pull-ups off while awake");
   AST_OSC_ON: assert property (SLEEP_N_I [*4] |-> OSC_EN_O)
      else $error("oscillator stopped while awake");
   AST_TRACK_HOLD: assert property (!TRACKING_EN_O |=> !TRACKING_EN_O)
      else $error("tracking resumed without reset");
   AST_FW_LOST: assert property (FIRMWARE_VALID_O == TRACKING_EN_O)
      else $error("firmware flag differs from tracking");
   cover property ($fell(TRACKING_EN_O));
   cover property (!SLEEP_N_I [*4]);
   cover property (!CHIP_SELECT_N_I ##1 CHIP_SELECT_N_I);
endmodule // pcp_top_asserts
bind pcp_top pcp_top_asserts u_asserts (
   .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .SCLK_I(SCLK_I),
   .CHIP_SELECT_N_I(CHIP_SELECT_N_I), .SLEEP_N_I(SLEEP_N_I), .MISO_O(MISO_O),
   .MISO_OE_O(MISO_OE_O), .PULLUP_EN_O(PULLUP_EN_O), .OSC_EN_O(OSC_EN_O),
   .LED_CTRL_O(LED_CTRL_O), .TRACKING_EN_O(TRACKING_EN_O),
   .FIRMWARE_VALID_O(FIRMWARE_VALID_O)
);
`default_nettype wire

// >>> test/pcp_host_model.sv
// Serial port master standing in for the host controller
`timescale 1ns/1ps
`default_nettype none
module pcp_host_model (
   // Serial pins
   output logic     sclk_o,
   output logic     mosi_o,
   output logic     cs_n_o,
   input wire logic miso_i,
   input wire logic miso_oe_i
);
   logic last_q;
   initial
   begin
      sclk_o = 1'b1;
      mosi_o = 1'b1;
      cs_n_o = 1'b1;
      last_q = 1'b0;
   end
   // ------------------------------------------------------------
   // Transfers; clock idles high and stands still outside frames
   // ------------------------------------------------------------
   // Short deselect pulse: any high level resets the port
   task automatic frame(input logic on);
      #100;
      cs_n_o = ~on;
      #400;
   endtask
   task automatic xbyte(input logic [7:0] o, output logic [7:0] i);
      for (int b = 7; b >= 0; b--)
      begin
         sclk_o = 1'b0;
         mosi_o = o[b];
         #100;
         sclk_o = 1'b1;
         // Undriven line: inverse of last bit, never a lucky match
         i[b] = miso_oe_i ? miso_i : ~last_q;
         last_q = i[b];
         #100;
      end
      mosi_o = ~mosi_o;
   endtask
endmodule // pcp_host_model
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench of the pixel capture serial port
`timescale 1ns/1ps
`default_nettype none
`include "pcp_defines.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("wrong value at %0t: %h vs %h", $time, (g), (e)); end end
module tb;
   localparam logic [7:0] PID_V = 8'ha7; // Arbitrary value
   localparam logic [7:0] FWR_V = 8'h6d; // Arbitrary value
   logic        clk, rst_n, sleep_n, pvalid, pstart, lwin, gen_en, armed;
   logic [5:0]  pdata;
   logic [7:0]  r;
   logic [31:0] seed;
   logic [5:0]  exp_mem [0:1535];
   int          error_cnt, num_checks, pcnt, stored, i;
   wire logic   sclk, mosi, cs_n, miso, miso_oe, pull_en, osc_en, led, track, fw_ok;
   pcp_top #(.PART_ID(PID_V), .FW_REV_ID(FWR_V)) dut (
      .CLK_I(clk), .RESET_N_I(rst_n), .SCLK_I(sclk), .MOSI_I(mosi),
      .CHIP_SELECT_N_I(cs_n), .MISO_O(miso), .MISO_OE_O(miso_oe),
      .PULLUP_EN_O(pull_en), .SLEEP_N_I(sleep_n), .OSC_EN_O(osc_en),
      .PIX_DATA_I(pdata), .PIX_VALID_I(pvalid), .PIX_FRAME_START_I(pstart),
      .LIGHT_WINDOW_I(lwin), .LED_CTRL_O(led), .TRACKING_EN_O(track),
      .FIRMWARE_VALID_O(fw_ok)
   );
   pcp_host_model host (.sclk_o(sclk), .mosi_o(mosi), .cs_n_o(cs_n),
      .miso_i(miso), .miso_oe_i(miso_oe));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic logic [7:0] pix_exp(input int k);
      if (k >= 1536)
         return 8'h00;
      return {1'b1, (k == 0) || (k == 900), exp_mem[k]};
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic xact(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      logic [7:0] x;
      @(posedge clk);
      #5;
      host.frame(1'b1);
      host.xbyte(a, x);
      host.xbyte(d, q);
      host.frame(1'b0);
   endtask
   task automatic rchk(input logic [6:0] a, input logic [7:0] e);
      logic [7:0] q;
      xact({1'b0, a}, 8'h00, q);
      `CHK(q, e)
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Clock, pixel source and watchdog
   // ------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // One pixel every other cycle, 900 to a frame
   always @(posedge clk)
   begin
      pvalid <= 1'b0;
      pstart <= 1'b0;
      if (gen_en && !pvalid)
      begin
         seed = xs(seed);
         pvalid <= 1'b1;
         pdata <= seed[5:0];
         pstart <= (pcnt == 0);
         armed = armed || (pcnt == 0);
         if (armed && stored < 1536)
         begin
            exp_mem[stored] = seed[5:0];
            stored++;
         end
         pcnt = (pcnt == 899) ? 0 : pcnt + 1;
      end
   end
   initial
   begin
      repeat (120000) @(posedge clk);
      error_cnt++;
      give_verdict();
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      rst_n = 1'b0;
      sleep_n = 1'b1;
      lwin = 1'b0;
      pdata = 6'h00;
      pvalid = 1'b0;
      pstart = 1'b0;
      gen_en = 1'b0;
      armed = 1'b0;
      seed = 32'd96543;
      {error_cnt, num_checks, pcnt, stored} = '0;
      tick(20);
      `CHK({pull_en, led, miso_oe, miso}, 4'h0)
      @(posedge clk);
      rst_n <= 1'b1;
      tick(4);
      `CHK({pull_en, led, track, fw_ok}, 4'hf)
      rchk(`PCP_ADDR_PART_ID, PID_V);
      rchk(`PCP_ADDR_PART_ID_COMPL, ~PID_V);
      rchk(`PCP_ADDR_FW_REVISION, FWR_V);
      rchk(7'h05, 8'h00);
      seed = xs(seed);
      xact({1'b1, 7'h05}, seed[7:0], r);
      rchk(`PCP_ADDR_CONFIG, `PCP_CONFIG_RESET);
      // Address byte of a write, then deselect before its data
      @(posedge clk);
      #5;
      host.frame(1'b1);
      host.xbyte({1'b1, `PCP_ADDR_CONFIG}, r);
      host.frame(1'b0);
      rchk(`PCP_ADDR_CONFIG, `PCP_CONFIG_RESET);
      xact({1'b1, `PCP_ADDR_CONFIG}, 8'h49, r);
      rchk(`PCP_ADDR_CONFIG, 8'h49);
      tick(4);
      `CHK(led, 1'b0)
      @(posedge clk);
      lwin <= 1'b1;
      tick(4);
      `CHK(led, 1'b1)
      // Random window pattern; light follows one cycle later
      for (i = 0; i < 16; i++)
      begin
         @(posedge clk);
         seed = xs(seed);
         lwin <= seed[0];
         @(posedge clk);
         #1;
         `CHK(led, seed[0])
      end
      xact({1'b1, `PCP_ADDR_CONFIG}, `PCP_CONFIG_RESET, r);
      @(posedge clk);
      lwin <= 1'b0;
      tick(4);
      `CHK(led, 1'b1)
      @(posedge clk);
      sleep_n <= 1'b0;
      tick(5);
      `CHK({led, pull_en, osc_en}, 3'h0)
      @(posedge clk);
      sleep_n <= 1'b1;
      tick(5);
      `CHK({led, pull_en, osc_en}, 3'h7)
      rchk(`PCP_ADDR_CONFIG, `PCP_CONFIG_RESET);
      xact({1'b1, `PCP_ADDR_FRAME_CAPTURE}, 8'h00, r);
      tick(4);
      `CHK({track, fw_ok}, 2'b00)
      rchk(`PCP_ADDR_FW_REVISION, 8'h00);
      rchk(`PCP_ADDR_PIXEL_BURST, 8'h00);
      rchk(`PCP_ADDR_FRAME_CAPTURE, 8'h00);
      @(posedge clk);
      gen_en <= 1'b1;
      for (i = 0; i < 20000 && stored < 1536; i++)
         @(posedge clk);
      `CHK(stored, 1536)
      tick(10);
      gen_en <= 1'b0;
      rchk(`PCP_ADDR_FRAME_CAPTURE, pix_exp(0));
      rchk(`PCP_ADDR_FRAME_CAPTURE, pix_exp(1));
      @(posedge clk);
      #5;
      host.frame(1'b1);
      host.xbyte({1'b0, `PCP_ADDR_PIXEL_BURST}, r);
      for (i = 0; i < 1538; i++)
      begin
         host.xbyte(8'h00, r);
         `CHK(r, pix_exp(i))
      end
      host.frame(1'b0);
      rchk(`PCP_ADDR_PART_ID, PID_V);
      @(posedge clk);
      rst_n <= 1'b0;
      tick(3);
      @(posedge clk);
      rst_n <= 1'b1;
      tick(4);
      `CHK({track, fw_ok}, 2'b11)
      rchk(`PCP_ADDR_FW_REVISION, FWR_V);
      give_verdict();
   end
endmodule // tb
`default_nettype wire
